// ---- rtl/comparator_status_interrupt_regs.sv ----
// register bank of the eight-channel comparator interface
// assumes an APB master on clk_sys; comparator outputs and ready flags
// arrive from the analog side unsynchronised, the rest from logic on clk_sys
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module comparator_status_interrupt_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// comparator side
	input  wire logic [7:0]  comparator_output,
	input  wire logic [7:0]  comparator_valid,
	input  wire logic [7:0]  channel_enable,
	input  wire logic [3:0]  window_inside_status,
	input  wire logic [3:0]  window_pair_irq,
	input  wire logic [7:0]  channel_compare_irq,
	input  wire logic        peripheral_event,
	output logic      [7:0]  channel_compare_in,
	output logic      [7:0]  startup_done,
	output logic             event_compare_start,
	output logic             interface_enable,
	output logic             irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] control_q;
	logic [31:0] mask_q;
	logic [31:0] pending_q;
	logic [31:0] pending_d;
	logic [7:0]  override_q;
	logic [7:0]  comp_meta_q;
	logic [7:0]  comp_sync_q;
	logic [7:0]  valid_meta_q;
	logic [7:0]  valid_sync_q;
	logic [7:0]  chan_on_q;
	logic [7:0]  started_q;
	logic [7:0]  started_d;
	localparam int STARTUP_CNT_W = comparator_regs_pkg::STARTUP_W;
	logic [STARTUP_CNT_W-1:0] start_cnt_q [8];
	logic [comparator_regs_pkg::GENERIC_CLOCK_DIV_W-1:0] generic_clock_div_q;
	logic        generic_clock_tick_q;
	logic [7:0]  comp_sel;
	logic [7:0]  chan_active;
	logic [31:0] status_word;
	logic [31:0] set_events;
	logic [31:0] rd_data;
	logic        addr_ok;
	logic        wr_en;
	logic        rd_phase;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// place two bits for each of the eight channels and four pair bits in the shared layout
	function automatic logic [31:0] pack_layout(input logic [7:0] even_bits,
	                                            input logic [7:0] odd_bits,
	                                            input logic [3:0] pair_bits);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int i = 0; i < comparator_regs_pkg::N_CHAN; i++) begin
			w[2*i]   = even_bits[i];
			w[2*i+1] = odd_bits[i];
		end
		w[comparator_regs_pkg::WIN_LSB +: comparator_regs_pkg::N_PAIR] = pair_bits;
		return w;
	endfunction : pack_layout

	function automatic logic is_offset(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : is_offset

	// ----------------------------------------------------------------
	// apb slave: one wait state, read latched as pready rises, write on the edge that ends pready
	// ----------------------------------------------------------------
	assign rd_phase = psel && penable && !pready;
	assign wr_en    = psel && penable && pready && pwrite && addr_ok;

	always_comb begin
		addr_ok = is_offset(paddr, comparator_regs_pkg::OFS_CONTROL)
			|| is_offset(paddr, comparator_regs_pkg::OFS_COMPARATOR_STATUS)
			|| is_offset(paddr, comparator_regs_pkg::OFS_INTERRUPT_ENABLE_SET)
			|| is_offset(paddr, comparator_regs_pkg::OFS_INTERRUPT_ENABLE_CLEAR)
			|| is_offset(paddr, comparator_regs_pkg::OFS_INTERRUPT_MASK)
			|| is_offset(paddr, comparator_regs_pkg::OFS_INTERRUPT_PENDING)
			|| is_offset(paddr, comparator_regs_pkg::OFS_INTERRUPT_PENDING_CLR)
			|| is_offset(paddr, comparator_regs_pkg::OFS_OUTPUT_OVERRIDE);
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr)
			comparator_regs_pkg::OFS_CONTROL:           rd_data = control_q;
			comparator_regs_pkg::OFS_COMPARATOR_STATUS: rd_data = status_word;
			comparator_regs_pkg::OFS_INTERRUPT_MASK:    rd_data = mask_q;
			comparator_regs_pkg::OFS_INTERRUPT_PENDING: rd_data = pending_q;
			comparator_regs_pkg::OFS_OUTPUT_OVERRIDE:   rd_data = {24'h00_0000, override_q};
			default:                                    rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= rd_phase;
			pslverr <= rd_phase && !addr_ok;
			if (rd_phase && !pwrite) begin
				prdata <= rd_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// control and override registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			control_q <= comparator_regs_pkg::RST_CONTROL;
		end else if (wr_en && is_offset(paddr, comparator_regs_pkg::OFS_CONTROL)) begin
			control_q <= pwdata & comparator_regs_pkg::CTL_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			override_q <= comparator_regs_pkg::RST_OVERRIDE;
		end else if (wr_en && is_offset(paddr, comparator_regs_pkg::OFS_OUTPUT_OVERRIDE)) begin
			override_q <= pwdata[comparator_regs_pkg::OVR_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// analog inputs: two-flop synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			comp_meta_q  <= 8'h00;
			comp_sync_q  <= 8'h00;
			valid_meta_q <= 8'h00;
			valid_sync_q <= 8'h00;
		end else begin
			comp_meta_q  <= comparator_output;
			comp_sync_q  <= comp_meta_q;
			valid_meta_q <= comparator_valid;
			valid_sync_q <= valid_meta_q;
		end
	end

	assign comp_sel = control_q[comparator_regs_pkg::CTL_TEST_BIT] ? override_q : comp_sync_q;

	assign chan_active = channel_enable & {8{control_q[comparator_regs_pkg::CTL_EN_BIT]}};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			channel_compare_in <= 8'h00;
			interface_enable   <= 1'b0;
		end else begin
			channel_compare_in <= comp_sel;
			interface_enable   <= control_q[comparator_regs_pkg::CTL_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// peripheral event trigger
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			event_compare_start <= 1'b0;
		end else begin
			event_compare_start <= peripheral_event
				&& control_q[comparator_regs_pkg::CTL_EVENT_BIT]
				&& control_q[comparator_regs_pkg::CTL_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// generic clock tick and per-channel startup timers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			generic_clock_div_q  <= '0;
			generic_clock_tick_q <= 1'b0;
		end else if (generic_clock_div_q ==
			comparator_regs_pkg::GENERIC_CLOCK_DIV_W'(comparator_regs_pkg::GENERIC_CLOCK_DIV - 1)) begin
			generic_clock_div_q  <= '0;
			generic_clock_tick_q <= 1'b1;
		end else begin
			generic_clock_div_q  <= generic_clock_div_q + 1'b1;
			generic_clock_tick_q <= 1'b0;
		end
	end

	// count startup ticks after each enable
	always_comb begin
		started_d = started_q;
		for (int i = 0; i < comparator_regs_pkg::N_CHAN; i++) begin
			if (!chan_active[i]) begin
				started_d[i] = 1'b0;
			end else if (generic_clock_tick_q && !started_q[i] && start_cnt_q[i] >=
				control_q[comparator_regs_pkg::CTL_STARTUP_LSB +: STARTUP_CNT_W]) begin
				started_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < comparator_regs_pkg::N_CHAN; i++) begin
				start_cnt_q[i] <= '0;
			end
			started_q <= 8'h00;
			chan_on_q <= 8'h00;
		end else begin
			chan_on_q <= chan_active;
			started_q <= started_d;
			for (int i = 0; i < comparator_regs_pkg::N_CHAN; i++) begin
				if (!chan_active[i] || !chan_on_q[i]) begin
					start_cnt_q[i] <= '0;
				end else if (generic_clock_tick_q && !started_q[i]) begin
					start_cnt_q[i] <= start_cnt_q[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			startup_done <= 8'h00;
		end else begin
			startup_done <= started_q;
		end
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	// status layout
	assign status_word = pack_layout(comp_sel & chan_active,
		valid_sync_q & chan_active & started_q,
		window_inside_status);

	// ----------------------------------------------------------------
	// interrupt mask
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask_q <= comparator_regs_pkg::RST_MASK;
		end else if (wr_en && is_offset(paddr,
			comparator_regs_pkg::OFS_INTERRUPT_ENABLE_SET)) begin
			mask_q <= mask_q | (pwdata & pack_layout(8'hff, 8'hff, 4'hf));
		end else if (wr_en && is_offset(paddr,
			comparator_regs_pkg::OFS_INTERRUPT_ENABLE_CLEAR)) begin
			mask_q <= mask_q & ~pwdata;
		end
	end

	// ----------------------------------------------------------------
	// interrupt pending: hardware set wins over software clear
	// ----------------------------------------------------------------
	// pending sources
	assign set_events = pack_layout(channel_compare_irq & chan_active,
		started_d & ~started_q,
		window_pair_irq & {4{control_q[comparator_regs_pkg::CTL_EN_BIT]}});

	always_comb begin
		pending_d = pending_q | set_events;
		if (wr_en && is_offset(paddr, comparator_regs_pkg::OFS_INTERRUPT_PENDING_CLR)) begin
			pending_d = (pending_q & ~pwdata) | set_events;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pending_q <= comparator_regs_pkg::RST_PENDING;
		end else begin
			pending_q <= pending_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(pending_d & mask_q);
		end
	end

endmodule : comparator_status_interrupt_regs

// ---- shared/comparator_regs_pkg.sv ----
// constants for the comparator interface register bank
// assumes a 32-bit APB slave and a 10 MHz system clock
package comparator_regs_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL                = 8'h00;
	localparam logic [7:0] OFS_COMPARATOR_STATUS      = 8'h04;
	localparam logic [7:0] OFS_INTERRUPT_ENABLE_SET   = 8'h10;
	localparam logic [7:0] OFS_INTERRUPT_ENABLE_CLEAR = 8'h14;
	localparam logic [7:0] OFS_INTERRUPT_MASK         = 8'h18;
	localparam logic [7:0] OFS_INTERRUPT_PENDING      = 8'h1c;
	localparam logic [7:0] OFS_INTERRUPT_PENDING_CLR  = 8'h20;
	localparam logic [7:0] OFS_OUTPUT_OVERRIDE        = 8'h24;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int CTL_EN_BIT         = 0;
	localparam int CTL_EVENT_BIT      = 1;
	localparam int CTL_TEST_BIT       = 7;
	localparam int CTL_STARTUP_LSB    = 8;
	localparam int STARTUP_W          = 10;
	localparam logic [31:0] CTL_WRITE_MASK = 32'h0003_ff83;

	// ----------------------------------------------------------------
	// status / interrupt layout
	// ----------------------------------------------------------------
	localparam int N_CHAN             = 8;
	localparam int N_PAIR             = 4;
	localparam int WIN_LSB            = 24;
	localparam int OVR_W              = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_CONTROL  = 32'h0000_0000;
	localparam logic [31:0] RST_MASK     = 32'h0000_0000;
	localparam logic [31:0] RST_PENDING  = 32'h0000_0000;
	localparam logic [7:0]  RST_OVERRIDE = 8'h00;

	// ----------------------------------------------------------------
	// timing: generic clock derived from the system clock
	// ----------------------------------------------------------------
	localparam int SYS_CLK_HZ         = 10_000_000;
	localparam int GENERIC_CLK_HZ     = 1_000_000;
	localparam int GENERIC_CLOCK_DIV           = SYS_CLK_HZ / GENERIC_CLK_HZ;
	localparam int GENERIC_CLOCK_DIV_W         = 4;

endpackage : comparator_regs_pkg

// ---- verif/comparator_regs_sva.sv ----
// port assertions for the comparator register bank
// assumes one clk_sys domain and a one-wait-state apb slave
`timescale 1ns/10ps
module comparator_regs_sva (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  comparator_output,
	input wire logic [7:0]  comparator_valid,
	input wire logic [7:0]  channel_enable,
	input wire logic [3:0]  window_inside_status,
	input wire logic [3:0]  window_pair_irq,
	input wire logic [7:0]  channel_compare_irq,
	input wire logic        peripheral_event,
	input wire logic [7:0]  channel_compare_in,
	input wire logic [7:0]  startup_done,
	input wire logic        event_compare_start,
	input wire logic        interface_enable,
	input wire logic        irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic wr_done;
	logic quiet;
	assign wr_done = psel && penable && pready && pwrite;
	assign quiet = !(|window_pair_irq) && !(|channel_compare_irq);
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no pready after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04,
		8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24}))
		else $error("pslverr does not match the address map");
	a_wo_read_zero: assert property (
		pready && !pwrite && paddr inside {8'h10, 8'h14, 8'h20} |-> prdata == 32'h0)
		else $error("write-only register read not zero");
	a_enable_follows: assert property (
		wr_done && paddr == 8'h00 |=> ##1 interface_enable == $past(pwdata[0], 2))
		else $error("interface enable not taken from control write");
	a_event_cause: assert property (
		event_compare_start |-> $past(peripheral_event) && $past(interface_enable))
		else $error("comparison start without enabled event");
	a_event_blocked: assert property (
		peripheral_event && !interface_enable |=> !event_compare_start)
		else $error("event accepted while disabled");
	a_irq_cause: assert property ($rose(irq) |-> ($past(wr_done) || $past(wr_done, 2)
		|| $past(!quiet)) or ##1 (startup_done != $past(startup_done)))
		else $error("irq rose without a source");
	a_clear_drops_irq: assert property (
		wr_done && paddr == 8'h20 && pwdata == 32'hffffffff && quiet
		|-> ##[1:2] !irq || startup_done != $past(startup_done, 2))
		else $error("irq stays after clearing all pending bits");
	a_disable_drops_irq: assert property (
		wr_done && paddr == 8'h14 && pwdata == 32'hffffffff |-> ##[1:2] !irq)
		else $error("irq stays after masking all sources");
endmodule : comparator_regs_sva
bind comparator_status_interrupt_regs comparator_regs_sva comparator_regs_sva_inst (.*);

// ---- verif/comparator_side_model.sv ----
// comparator channels and window pairs seen from the register bank
// assumes the bench calls its tasks
`timescale 1ns/10ps
module comparator_side_model (
	input  wire logic       clk_sys,
	output logic      [7:0] comparator_output,
	output logic      [7:0] comparator_valid,
	output logic      [7:0] channel_enable,
	output logic      [3:0] window_inside_status,
	output logic      [3:0] window_pair_irq,
	output logic      [7:0] channel_compare_irq,
	output logic            peripheral_event
);
	initial begin
		{comparator_output, comparator_valid, channel_enable} = 24'h0;
		{window_inside_status, window_pair_irq, channel_compare_irq, peripheral_event} = 17'h0;
	end
	task automatic set_levels(input logic [7:0] c, input logic [7:0] v, input logic [7:0] e,
		input logic [3:0] w);
		@(posedge clk_sys);
		comparator_output <= c;
		comparator_valid <= v;
		channel_enable <= e;
		window_inside_status <= w;
	endtask : set_levels
	task automatic pulse(input logic [3:0] w, input logic [7:0] c, input logic ev);
		@(posedge clk_sys);
		window_pair_irq <= w;
		channel_compare_irq <= c;
		peripheral_event <= ev;
		@(posedge clk_sys);
		{window_pair_irq, channel_compare_irq, peripheral_event} <= 13'h0;
	endtask : pulse
endmodule : comparator_side_model

// ---- verif/test_comparator_status_interrupt_regs.sv ----
// self-checking bench for the comparator register bank
// assumes the side model drives all comparator-side inputs
`timescale 1ns/10ps
module test_comparator_status_interrupt_regs;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, last_err;
	logic        peripheral_event, event_compare_start, interface_enable, irq;
	logic [7:0]  paddr, comparator_output, comparator_valid, channel_enable;
	logic [7:0]  channel_compare_irq, channel_compare_in, startup_done;
	logic [3:0]  window_inside_status, window_pair_irq;
	logic [31:0] pwdata, prdata;
	logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h18, 8'h1c, 8'h24};
	int          mismatches, n_compared;
	comparator_status_interrupt_regs comparator_status_interrupt_regs_inst (.*);
	comparator_side_model comparator_side_model_inst (.*);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_compared++;
		if (seen !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			check("pready", 32'h0, 32'h1);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		check(nm, r, e);
	endtask : rdc
	function automatic logic [31:0] st(input logic [3:0] w, input logic [7:0] rdy,
		input logic [7:0] cs);
		logic [31:0] v;
		v = {4'h0, w, 24'h0};
		for (int i = 0; i < 8; i++) begin
			v[2*i] = cs[i];
			v[2*i+1] = rdy[i];
		end
		return v;
	endfunction : st
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		wrap_up();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rdc("reset value", ofs[i], 32'h0);
		end
		wr(8'h24, 32'hffffffff);
		rdc("override", 8'h24, 32'h000000ff);
		rdc("unmapped", 8'h08, 32'h0);
		check("slverr", {31'h0, last_err}, 32'h1);
		wr(8'h18, 32'hffffffff);
		wr(8'h10, 32'h0f00ffff);
		rdc("mask set", 8'h18, 32'h0f00ffff);
		wr(8'h14, 32'h0100aaaa);
		rdc("mask clear", 8'h18, 32'h0e005555);
		rdc("wo read", 8'h10, 32'h0);
		check("irq idle", {31'h0, irq}, 32'h0);
		wr(8'h00, 32'h00000001);
		comparator_side_model_inst.pulse(4'h6, 8'h00, 1'b0);
		rdc("win pend", 8'h1c, 32'h06000000);
		check("irq win", {31'h0, irq}, 32'h1);
		wr(8'h20, 32'h02000000);
		rdc("pend clr", 8'h1c, 32'h04000000);
		wr(8'h14, 32'h04000000);
		repeat (3) @(negedge clk_sys);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(8'h20, 32'hffffffff);
		wr(8'h00, 32'h00000003);
		comparator_side_model_inst.set_levels(8'ha5, 8'hff, 8'hff, 4'h9);
		repeat (40) @(negedge clk_sys);
		check("enable", {31'h0, interface_enable}, 32'h1);
		rdc("status", 8'h04, st(4'h9, 8'hff, 8'ha5));
		rdc("sut pend", 8'h1c, 32'h0000aaaa);
		comparator_side_model_inst.pulse(4'h0, 8'h00, 1'b1);
		@(negedge clk_sys);
		check("event on", {31'h0, event_compare_start}, 32'h1);
		wr(8'h00, 32'h00000001);
		comparator_side_model_inst.pulse(4'h0, 8'h00, 1'b1);
		@(negedge clk_sys);
		check("event off", {31'h0, event_compare_start}, 32'h0);
		comparator_side_model_inst.pulse(4'h0, 8'h81, 1'b0);
		rdc("cmp pend", 8'h1c, 32'h0000eaab);
		check("irq cmp", {31'h0, irq}, 32'h1);
		wr(8'h20, 32'hffffffff);
		repeat (3) @(negedge clk_sys);
		check("irq clr", {31'h0, irq}, 32'h0);
		comparator_side_model_inst.set_levels(8'ha5, 8'h0f, 8'hff, 4'h9);
		repeat (10) @(negedge clk_sys);
		rdc("ready", 8'h04, st(4'h9, 8'h0f, 8'ha5));
		wr(8'h24, 32'h0000003c);
		wr(8'h00, 32'h00000081);
		repeat (10) @(negedge clk_sys);
		check("test out", {24'h0, channel_compare_in}, 32'h0000003c);
		rdc("test status", 8'h04, st(4'h9, 8'h0f, 8'h3c));
		wr(8'h00, 32'h00000501);
		comparator_side_model_inst.set_levels(8'ha5, 8'hff, 8'h00, 4'h9);
		repeat (3) @(negedge clk_sys);
		comparator_side_model_inst.set_levels(8'ha5, 8'hff, 8'hff, 4'h9);
		repeat (30) @(negedge clk_sys);
		check("sut early", {24'h0, startup_done}, 32'h0);
		repeat (60) @(negedge clk_sys);
		check("sut done", {24'h0, startup_done}, 32'h000000ff);
		wr(8'h14, 32'hffffffff);
		rdc("mask off", 8'h18, 32'h0);
		wr(8'h00, 32'h0);
		repeat (2) @(negedge clk_sys);
		check("disable", {31'h0, interface_enable}, 32'h0);
		comparator_side_model_inst.pulse(4'h0, 8'h00, 1'b1);
		@(negedge clk_sys);
		check("event disabled", {31'h0, event_compare_start}, 32'h0);
		wrap_up();
	end
endmodule : test_comparator_status_interrupt_regs
